// >>> include/nand_host_pkg.sv
// shared constants, types and helpers of the NAND host controller
package nand_host_pkg;

  // clock and pin timing
  localparam int CLK_NS        = 40;
  localparam int T_SETUP_NS    = 40;
  localparam int T_LOW_NS      = 40;
  localparam int T_HIGH_NS     = 40;
  localparam int T_WB_NS       = 100;
  // three stages plus the agreement flop before a pin change is seen
  localparam int SYNC_DLY      = 4;

  // a least time rounds up, never below one cycle
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int SETUP_CYC = cyc_min(T_SETUP_NS);
  localparam int LOW_CYC   = cyc_min(T_LOW_NS);
  localparam int HIGH_CYC  = cyc_min(T_HIGH_NS);
  localparam int WB_CYC    = cyc_min(T_WB_NS);

  // register map, byte offsets on the bus
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_CMD   = 8'h04;
  localparam logic [7:0] OFF_STAT  = 8'h08;
  localparam logic [7:0] OFF_RDATA = 8'h0C;
  localparam logic [7:0] OFF_ID    = 8'h10;
  localparam logic [7:0] OFF_COL   = 8'h14;

  // field positions
  localparam int CTRL_CE_HOLD = 0;
  localparam int CTRL_WP_OFF  = 1;
  localparam int CTRL_EDO     = 2;
  localparam int CMD_KIND_LSB = 8;
  localparam int ST_ENGINE    = 0;
  localparam int ST_RB_BUSY   = 1;
  localparam int ST_REFUSED   = 2;
  localparam int ST_CACHE     = 3;
  localparam int ST_MP_LOCK   = 4;
  localparam int ST_MP_READ   = 5;
  localparam int ST_ID_MODE   = 6;
  localparam int ID5_PLANE_LSB = 2;
  localparam int ID5_ECC_LSB   = 4;
  localparam int ID6_TECH_LSB  = 0;
  localparam int ID6_EDO_BIT   = 6;
  localparam int ID6_DDR_BIT   = 7;
  localparam logic [2:0] ID5_IDX = 3'h4;
  localparam logic [2:0] ID6_IDX = 3'h5;

  // reset values
  localparam logic [2:0]  CTRL_RST = 3'h0;
  localparam logic [13:0] COL_RST  = 14'h0000;

  // array geometry
  localparam logic [15:0] PAGE_BYTES    = 16'h21C0;
  localparam logic [7:0]  LAST_PAGE_BLK = 8'hFF;

  // command codes
  localparam logic [7:0] C_READ        = 8'h00;
  localparam logic [7:0] C_RD_COL      = 8'h05;
  localparam logic [7:0] C_PROG_CONF   = 8'h10;
  localparam logic [7:0] C_PROG_1ST    = 8'h11;
  localparam logic [7:0] C_CACHE_PROG  = 8'h15;
  localparam logic [7:0] C_READ_CONF   = 8'h30;
  localparam logic [7:0] C_CACHE_NEXT  = 8'h31;
  localparam logic [7:0] C_MP_CACHE    = 8'h33;
  localparam logic [7:0] C_CACHE_END   = 8'h3F;
  localparam logic [7:0] C_MP_SETUP    = 8'h60;
  localparam logic [7:0] C_STATUS      = 8'h70;
  localparam logic [7:0] C_MP_STATUS   = 8'h78;
  localparam logic [7:0] C_PROG        = 8'h80;
  localparam logic [7:0] C_PROG_2ND    = 8'h81;
  localparam logic [7:0] C_PROG_COL    = 8'h85;
  localparam logic [7:0] C_READ_ID     = 8'h90;
  localparam logic [7:0] C_ERASE_CONF  = 8'hD0;
  localparam logic [7:0] C_RESET       = 8'hFF;

  typedef enum logic [1:0] {
    KIND_CMD  = 2'h0,
    KIND_ADDR = 2'h1,
    KIND_DIN  = 2'h2,
    KIND_DOUT = 2'h3
  } kind_t;

  typedef struct packed {
    kind_t      kind;
    logic [7:0] data;
  } cyc_req_t;

  typedef struct packed {
    logic       cle;
    logic       ale;
    logic       ce_n;
    logic       we_n;
    logic       read_strobe_n;
    logic       wp_n;
    logic       io_oe;
    logic [7:0] io_out;
  } nand_pins_t;

endpackage

// >>> rtl/pin_sync3.sv
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int          W   = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a bit moves only once the later two stages agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= INIT;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

// >>> rtl/nand_host_ctrl.sv
// NAND flash host: AHB-Lite command registers driving the flash bus pins
// Functional notes
// - commands latched CLE high, ALE low, idle
// - data out: CLE, ALE low, WE, WP high
// - random data out stays inside the page
// - both planes get the same page address
// - multi-plane random out only after multi-plane read
// - multi-plane reads only on multi-plane programmed pages (not checked here; left to software)
// - cache read sequence stays in one block
// - multi-plane cache read ends by 3Fh or reset
// - between 11h and 81h only 70h/78h/FFh
// - random data input stays inside page buffer
// - page read 00h, five addresses, 30h, busy
// - ID read is 90h, address 00h, six bytes
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module nand_host_ctrl
  import nand_host_pkg::*;
#(
  parameter logic [7:0] MP_RDOUT_CMD = 8'h06
) (
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        ARST_N,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // flash pins
  output nand_pins_t       NAND_PINS,
  input  wire logic [7:0]  NAND_IO_IN,
  input  wire logic        NAND_RB_N
);

  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_LOW, S_HIGH, S_WB, S_RB} state_t;

  function automatic logic busy_exempt(input logic [7:0] c);
    return c == C_RESET || c == C_STATUS || c == C_MP_STATUS;
  endfunction

  function automatic logic starts_busy(input logic [7:0] c);
    return c == C_READ_CONF || c == C_CACHE_NEXT || c == C_MP_CACHE ||
           c == C_CACHE_END || c == C_PROG_CONF || c == C_PROG_1ST ||
           c == C_CACHE_PROG || c == C_ERASE_CONF || c == C_RESET;
  endfunction

  function automatic logic [7:0] cnt8(input int n);
    return 8'(n - 1);
  endfunction

  logic [7:0] io_s;
  logic       rb_s;

  pin_sync3 #(.W(8), .INIT(8'h00)) u_io_sync (
    .clk   (REF_CLK),
    .rst_n (ARST_N),
    .d     (NAND_IO_IN),
    .q     (io_s)
  );

  pin_sync3 #(.W(1), .INIT(1'b1)) u_rb_sync (
    .clk   (REF_CLK),
    .rst_n (ARST_N),
    .d     (NAND_RB_N),
    .q     (rb_s)
  );

  // bus slave state
  logic        ap_wr_q;
  logic [7:0]  ap_addr_q;
  logic [2:0]  ctrl_q;
  logic        refused_q;
  logic [7:0]  rdata_q;
  logic [7:0]  id5_q;
  logic [7:0]  id6_q;
  logic [13:0] col_q;
  // engine state
  state_t      state_q;
  logic [7:0]  cnt_q;
  cyc_req_t    req_q;
  nand_pins_t  pins_q;
  // sequence tracking
  logic [7:0]  last_cmd_q;
  logic [2:0]  aidx_q;
  logic [7:0]  col_lo_q;
  logic        id_mode_q;
  logic [2:0]  id_cnt_q;
  logic        cache_q;
  logic [7:0]  page_q;
  logic        mp_pend_q;
  logic        mp_lock_q;
  logic        mp_read_q;
  logic [7:0]  mp_page_q;

  logic        cmd_wr;
  logic        stat_wr;
  logic        ctrl_wr;
  cyc_req_t    wreq;
  logic        refuse;
  logic        launch;
  logic [2:0]  page_idx;
  logic        col_chk;
  logic        is_read;
  logic        edo;

  assign cmd_wr   = ap_wr_q && ap_addr_q == OFF_CMD;
  assign stat_wr  = ap_wr_q && ap_addr_q == OFF_STAT;
  assign ctrl_wr  = ap_wr_q && ap_addr_q == OFF_CTRL;
  assign wreq     = cyc_req_t'(HWDATA[CMD_KIND_LSB+1:0]);
  assign page_idx = (last_cmd_q == C_MP_SETUP) ? 3'h0 : 3'h2;
  assign col_chk  = last_cmd_q == C_READ || last_cmd_q == C_RD_COL ||
                    last_cmd_q == C_PROG || last_cmd_q == C_PROG_COL ||
                    last_cmd_q == MP_RDOUT_CMD;
  assign is_read  = req_q.kind == KIND_DOUT;
  assign edo      = ctrl_q[CTRL_EDO];

  // software orders are screened before they reach the pins
  always_comb begin
    refuse = state_q != S_IDLE;
    case (wreq.kind)
      KIND_CMD: begin
        if (!rb_s && !busy_exempt(wreq.data)) refuse = 1'b1;
        if (mp_lock_q && !busy_exempt(wreq.data) && wreq.data != C_PROG_2ND) begin
          refuse = 1'b1;
        end
        if (cache_q && !(busy_exempt(wreq.data) || wreq.data == C_CACHE_NEXT ||
            wreq.data == C_READ || wreq.data == C_CACHE_END)) begin
          refuse = 1'b1;
        end
        if (wreq.data == C_CACHE_NEXT && page_q == LAST_PAGE_BLK) refuse = 1'b1;
        if (wreq.data == MP_RDOUT_CMD && !mp_read_q) refuse = 1'b1;
      end
      KIND_ADDR: begin
        if (last_cmd_q == C_READ_ID && aidx_q == 3'h0 && wreq.data != 8'h00) begin
          refuse = 1'b1;
        end
        if (col_chk && aidx_q == 3'h1 && {wreq.data, col_lo_q} >= PAGE_BYTES) begin
          refuse = 1'b1;
        end
        if (mp_pend_q && aidx_q == page_idx && wreq.data != mp_page_q &&
            (last_cmd_q == C_MP_SETUP || last_cmd_q == C_PROG_2ND)) begin
          refuse = 1'b1;
        end
      end
      KIND_DIN: begin
        if (!rb_s) refuse = 1'b1;
      end
      default: begin
      end
    endcase
  end

  assign launch = cmd_wr && !refuse;

  // AHB-Lite address phase capture; zero wait states, always OKAY
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ap_wr_q   <= 1'b0;
      ap_addr_q <= 8'h00;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      ap_wr_q   <= HSEL && HREADY && HTRANS[1] && HWRITE;
      ap_addr_q <= HADDR[7:0];
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      HRDATA <= 32'h0000_0000;
    end else if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
      case (HADDR[7:0])
        OFF_CTRL:  HRDATA <= {29'h0, ctrl_q};
        OFF_CMD:   HRDATA <= {22'h0, req_q};
        OFF_STAT:  HRDATA <= {25'h0, id_mode_q, mp_read_q, mp_lock_q, cache_q,
                              refused_q, !rb_s, state_q != S_IDLE};
        OFF_RDATA: HRDATA <= {24'h0, rdata_q};
        // decoded geometry: {ddr, edo, tech[2:0], ecc[2:0], planes[1:0]}
        OFF_ID:    HRDATA <= {22'h0, id6_q[ID6_DDR_BIT], id6_q[ID6_EDO_BIT],
                              id6_q[ID6_TECH_LSB+:3], id5_q[ID5_ECC_LSB+:3],
                              id5_q[ID5_PLANE_LSB+:2]};
        OFF_COL:   HRDATA <= {18'h0, col_q};
        default:   HRDATA <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_q <= CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_q <= HWDATA[2:0];
    end
  end

  // a refusal in the same cycle as the clear keeps the flag
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      refused_q <= 1'b0;
    end else if (cmd_wr && refuse) begin
      refused_q <= 1'b1;
    end else if (stat_wr && HWDATA[ST_REFUSED]) begin
      refused_q <= 1'b0;
    end
  end

  // pin sequencer: setup, strobe low, strobe high, then busy wait
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= S_IDLE;
      cnt_q   <= 8'h00;
      req_q   <= '0;
      rdata_q <= 8'h00;
      pins_q  <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1,
                   read_strobe_n: 1'b1, wp_n: 1'b0, io_oe: 1'b0, io_out: 8'h00};
    end else begin
      case (state_q)
        S_IDLE: begin
          // standby unless software keeps the chip selected
          pins_q.ce_n <= !ctrl_q[CTRL_CE_HOLD];
          pins_q.wp_n <= ctrl_q[CTRL_WP_OFF];
          if (launch) begin
            req_q         <= wreq;
            pins_q.ce_n   <= 1'b0;
            pins_q.cle    <= wreq.kind == KIND_CMD;
            pins_q.ale    <= wreq.kind == KIND_ADDR;
            pins_q.io_oe  <= wreq.kind != KIND_DOUT;
            pins_q.io_out <= wreq.data;
            if (wreq.kind == KIND_DOUT) pins_q.wp_n <= 1'b1;
            cnt_q   <= cnt8(SETUP_CYC);
            state_q <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (cnt_q == 8'h00) begin
            if (is_read) begin
              pins_q.read_strobe_n <= 1'b0;
              // without EDO the byte must be caught before the strobe rises
              cnt_q <= edo ? cnt8(LOW_CYC) : cnt8(LOW_CYC + SYNC_DLY);
            end else begin
              pins_q.we_n <= 1'b0;
              cnt_q       <= cnt8(LOW_CYC);
            end
            state_q <= S_LOW;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        S_LOW: begin
          if (cnt_q == 8'h00) begin
            if (is_read && !edo) rdata_q <= io_s;
            pins_q.we_n          <= 1'b1;
            pins_q.read_strobe_n <= 1'b1;
            cnt_q   <= (is_read && edo) ? cnt8(HIGH_CYC + SYNC_DLY) : cnt8(HIGH_CYC);
            state_q <= S_HIGH;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        S_HIGH: begin
          if (cnt_q == 8'h00) begin
            // extended data-out keeps the byte past the rising strobe
            if (is_read && edo) rdata_q <= io_s;
            pins_q.cle   <= 1'b0;
            pins_q.ale   <= 1'b0;
            pins_q.io_oe <= 1'b0;
            if (req_q.kind == KIND_CMD && starts_busy(req_q.data)) begin
              cnt_q   <= cnt8(WB_CYC);
              state_q <= S_WB;
            end else begin
              state_q <= S_IDLE;
            end
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        S_WB: begin
          // busy only reaches the pin some time after the confirm
          if (cnt_q == 8'h00) begin
            state_q <= S_RB;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        S_RB: begin
          if (rb_s) state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  assign NAND_PINS = pins_q;

  // address cycle bookkeeping and column pointer
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      last_cmd_q <= C_RESET;
      aidx_q     <= 3'h0;
      col_lo_q   <= 8'h00;
      col_q      <= COL_RST;
      page_q     <= 8'h00;
    end else if (launch) begin
      case (wreq.kind)
        KIND_CMD: begin
          last_cmd_q <= wreq.data;
          aidx_q     <= 3'h0;
          if (wreq.data == C_CACHE_NEXT || wreq.data == C_CACHE_END) begin
            col_q <= COL_RST;
          end
          if (wreq.data == C_CACHE_NEXT) page_q <= page_q + 8'h01;
        end
        KIND_ADDR: begin
          aidx_q <= aidx_q + 3'h1;
          if (aidx_q == 3'h0) col_lo_q <= wreq.data;
          if (col_chk && aidx_q == 3'h1) col_q <= {wreq.data[5:0], col_lo_q};
          if (aidx_q == page_idx) page_q <= wreq.data;
        end
        default: begin
          col_q <= col_q + 14'h0001;
        end
      endcase
    end
  end

  // multi-plane and cache modes
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cache_q   <= 1'b0;
      mp_pend_q <= 1'b0;
      mp_lock_q <= 1'b0;
      mp_read_q <= 1'b0;
      mp_page_q <= 8'h00;
    end else if (launch && wreq.kind == KIND_CMD) begin
      case (wreq.data)
        C_CACHE_NEXT: cache_q <= 1'b1;
        C_MP_CACHE: begin
          cache_q   <= 1'b1;
          mp_read_q <= mp_pend_q;
          mp_pend_q <= 1'b0;
        end
        C_CACHE_END: cache_q <= 1'b0;
        C_READ_CONF: begin
          mp_read_q <= mp_pend_q;
          mp_pend_q <= 1'b0;
        end
        C_PROG_1ST: begin
          mp_lock_q <= 1'b1;
          mp_pend_q <= 1'b1;
        end
        C_PROG_2ND: mp_lock_q <= 1'b0;
        C_PROG_CONF, C_CACHE_PROG, C_ERASE_CONF: mp_pend_q <= 1'b0;
        C_RESET: begin
          cache_q   <= 1'b0;
          mp_pend_q <= 1'b0;
          mp_lock_q <= 1'b0;
          mp_read_q <= 1'b0;
        end
        default: begin
        end
      endcase
    end else if (launch && wreq.kind == KIND_ADDR && aidx_q == page_idx) begin
      if (!mp_pend_q && (last_cmd_q == C_MP_SETUP || last_cmd_q == C_PROG)) begin
        mp_page_q <= wreq.data;
        if (last_cmd_q == C_MP_SETUP) mp_pend_q <= 1'b1;
      end
    end
  end

  // identifier capture; bytes five and six feed the geometry register
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      id_mode_q <= 1'b0;
      id_cnt_q  <= 3'h0;
      id5_q     <= 8'h00;
      id6_q     <= 8'h00;
    end else begin
      if (launch && wreq.kind == KIND_CMD) begin
        id_mode_q <= wreq.data == C_READ_ID;
        id_cnt_q  <= 3'h0;
      end
      if (id_mode_q && is_read && state_q == S_HIGH && cnt_q == 8'h00) begin
        id_cnt_q <= id_cnt_q + 3'h1;
        if (id_cnt_q == ID5_IDX) id5_q <= edo ? io_s : rdata_q;
        if (id_cnt_q == ID6_IDX) id6_q <= edo ? io_s : rdata_q;
      end
    end
  end

  // multi-plane reads on pages not written as multi-plane are left to software
  logic unused_ok;
  assign unused_ok = ^{HSIZE, HWDATA[31:10], HADDR[31:8]};

endmodule

// >>> verification/nand_flash_model.sv
// behavioural flash device seen from the host controller's pins
`timescale 1ns/1ps
module nand_flash_model
  import nand_host_pkg::*;
#(
  parameter int         BUSY_NS = 2000,
  parameter int         HOLD_NS = 240,
  parameter logic [7:0] MAKER   = 8'h5A  // arbitrary value
) (
  // pins from the host
  input  wire nand_pins_t pins,
  // answers to the host
  output logic [7:0]      io,
  output logic            rb_n
);
  logic [7:0]  pg  [0:255];
  logic [7:0]  idb [0:5];
  logic [7:0]  cmd;
  logic [13:0] col;
  logic [2:0]  idx;
  logic        idm;
  logic        cache;
  int          acnt;
  event        go_busy;

  initial begin
    io = 8'h00;
    rb_n = 1'b1;
    cmd = 8'h00;
    col = 14'h0000;
    idx = 3'h0;
    idm = 1'b0;
    cache = 1'b0;
    acnt = 0;
    for (int i = 0; i < 256; i++) pg[i] = 8'(i);
    idb = '{MAKER, 8'h11, 8'h22, 8'h33, 8'h64, 8'h42};
  end

  always @(posedge pins.we_n) if (!pins.ce_n) begin
    if (pins.cle && !pins.ale) begin
      if ((rb_n || pins.io_out inside {C_RESET, C_STATUS, C_MP_STATUS}) &&
          (!cache || pins.io_out inside {C_CACHE_NEXT, C_STATUS, C_MP_STATUS,
                                         C_READ, C_RESET, C_CACHE_END})) begin
        cmd = pins.io_out;
        acnt = 0;
        idm = 1'b0;
        cache = (cmd == C_CACHE_NEXT) || (cache && cmd inside {C_STATUS, C_MP_STATUS, C_READ});
        if (cmd inside {C_CACHE_NEXT, C_CACHE_END}) col = 14'h0000;
        if (cmd inside {C_READ_CONF, C_CACHE_NEXT, C_MP_CACHE, C_CACHE_END, C_PROG_CONF,
                        C_PROG_1ST, C_CACHE_PROG, C_ERASE_CONF, C_RESET}) -> go_busy;
      end
    end else if (pins.ale && !pins.cle) begin
      if (acnt == 0) col[7:0] = pins.io_out;
      else if (acnt == 1) col[13:8] = pins.io_out[5:0];
      if (cmd == C_READ_ID) begin
        idm = 1'b1;
        idx = 3'h0;
      end
      acnt++;
    end else if (!pins.cle && rb_n) begin
      pg[col[7:0]] = pins.io_out;
      col++;
    end
  end

  always @(negedge pins.read_strobe_n)
    if (!pins.ce_n && !pins.cle && !pins.ale && pins.we_n) begin
      if (idm) begin
        io = idb[idx];
        idx++;
      end else if (cmd inside {C_STATUS, C_MP_STATUS}) io = {rb_n, rb_n, 6'h00};
      else begin
        io = pg[col[7:0]];
        col++;
      end
    end

  // the byte outlives the rising strobe only for the hold time, then goes stale
  always begin
    @(posedge pins.read_strobe_n);
    #HOLD_NS;
    if (pins.read_strobe_n) io = ~io;
  end

  always begin
    @(go_busy);
    rb_n = 1'b0;
    #BUSY_NS;
    rb_n = 1'b1;
  end
endmodule

// >>> verification/nand_host_ctrl_properties.sv
// concurrent checks on the host controller's ports
`timescale 1ns/1ps
module nand_host_ctrl_properties
  import nand_host_pkg::*;
(
  // clock and reset
  input wire logic       REF_CLK,
  input wire logic       ARST_N,
  // bus
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic [1:0] HTRANS,
  input wire logic       HREADY,
  input wire logic       HREADYOUT,
  input wire logic       HRESP,
  // flash pins
  input wire nand_pins_t NAND_PINS
);
  default clocking dc @(posedge REF_CLK);
  endclocking
  default disable iff (!ARST_N);

  // tracks the read mode written to the control register
  logic ctrl_wr_q;
  logic edo_q;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_wr_q <= 1'b0;
      edo_q     <= 1'b0;
    end else begin
      ctrl_wr_q <= HSEL && HREADY && HTRANS[1] && HWRITE && HADDR[7:0] == OFF_CTRL;
      if (ctrl_wr_q) edo_q <= HWDATA[CTRL_EDO];
    end
  end

  property p_latch_sel; !(NAND_PINS.cle && NAND_PINS.ale); endproperty
  a_latch_sel: assert property (p_latch_sel) else $error("cle and ale high together");
  property p_one_strobe; !(!NAND_PINS.we_n && !NAND_PINS.read_strobe_n); endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
  property p_we_ce; !NAND_PINS.we_n |-> !NAND_PINS.ce_n; endproperty
  a_we_ce: assert property (p_we_ce) else $error("write strobe without chip enable");
  property p_re_ce; !NAND_PINS.read_strobe_n |-> !NAND_PINS.ce_n; endproperty
  a_re_ce: assert property (p_re_ce) else $error("read strobe without chip enable");
  property p_we_setup;
    $fell(NAND_PINS.we_n) |-> !$past(NAND_PINS.ce_n) && $stable(NAND_PINS.cle) &&
      $stable(NAND_PINS.ale) && $stable(NAND_PINS.io_out) && NAND_PINS.io_oe;
  endproperty
  a_we_setup: assert property (p_we_setup) else $error("latch setup broken");
  property p_we_hold;
    $rose(NAND_PINS.we_n) |-> !NAND_PINS.ce_n && $stable(NAND_PINS.io_out) && NAND_PINS.io_oe;
  endproperty
  a_we_hold: assert property (p_we_hold) else $error("data moved at strobe rise");
  property p_dout;
    !NAND_PINS.read_strobe_n |-> !NAND_PINS.cle && !NAND_PINS.ale && NAND_PINS.we_n &&
      NAND_PINS.wp_n && !NAND_PINS.io_oe;
  endproperty
  a_dout: assert property (p_dout) else $error("pins wrong during data output");
  property p_re_len;
    $fell(NAND_PINS.read_strobe_n) && !edo_q |->
      !NAND_PINS.read_strobe_n[*5] ##1 NAND_PINS.read_strobe_n;
  endproperty
  a_re_len: assert property (p_re_len) else $error("read strobe low time wrong");
  property p_re_edo;
    $fell(NAND_PINS.read_strobe_n) && edo_q |->
      !NAND_PINS.read_strobe_n ##1 NAND_PINS.read_strobe_n[*5];
  endproperty
  a_re_edo: assert property (p_re_edo) else $error("extended read strobe timing wrong");
  property p_bus_ok; HSEL && HTRANS[1] && HREADY |=> HREADYOUT && !HRESP; endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus answer not ready or not okay");

  c_cmd: cover property ($rose(NAND_PINS.we_n) && NAND_PINS.cle);
  c_addr: cover property ($rose(NAND_PINS.we_n) && NAND_PINS.ale);
  c_read: cover property ($rose(NAND_PINS.read_strobe_n));
endmodule

// >>> verification/nand_host_ctrl_test.sv
// self-checking bench for the NAND host controller
`timescale 1ns/1ps
module nand_host_ctrl_test;
  import nand_host_pkg::*;
  localparam logic [7:0] MAKER_ID = 8'h5A;  // arbitrary value
  localparam logic [7:0] MP_RD    = 8'h06;
  logic        REF_CLK = 1'b0;
  logic        ARST_N = 1'b0;
  logic        HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0]  HTRANS = 2'h0;
  logic        HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic        HREADYOUT;
  logic        HRESP;
  logic        NAND_RB_N;
  logic [7:0]  NAND_IO_IN;
  nand_pins_t  NAND_PINS;
  logic [31:0] rd;
  int          error_cnt = 0;
  int          total_checks = 0;

  always #20 REF_CLK = ~REF_CLK;

  nand_host_ctrl #(.MP_RDOUT_CMD(MP_RD)) i_nand_host_ctrl (
    .REF_CLK(REF_CLK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .NAND_PINS(NAND_PINS), .NAND_IO_IN(NAND_IO_IN),
    .NAND_RB_N(NAND_RB_N));
  nand_flash_model #(.MAKER(MAKER_ID)) i_nand_flash_model (
    .pins(NAND_PINS), .io(NAND_IO_IN), .rb_n(NAND_RB_N));

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 50);
    if (HREADYOUT !== 1'b1) begin
      error_cnt++;
      tally_and_finish;
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HADDR <= {24'h0, a};
    HTRANS <= 2'h2;
    HWRITE <= wr;
    wait_ready;
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_ready;
    rd = HRDATA;
  endtask
  // every flash cycle waits for the engine, so no order of requests can overlap
  task automatic op(input logic [1:0] k, input logic [7:0] b);
    int n;
    ahb(1'b1, OFF_CMD, {22'h0, k, b});
    n = 0;
    do begin
      ahb(1'b0, OFF_STAT, 32'h0);
      n++;
    end while (rd[ST_ENGINE] !== 1'b0 && n < 400);
    if (n >= 400) begin
      error_cnt++;
      tally_and_finish;
    end
  endtask
  task automatic cmd(input logic [7:0] b);
    op(KIND_CMD, b);
  endtask
  task automatic adr5(input logic [7:0] c, input logic [7:0] p);
    op(KIND_ADDR, c);
    op(KIND_ADDR, 8'h00);
    op(KIND_ADDR, p);
    op(KIND_ADDR, 8'h00);
    op(KIND_ADDR, 8'h00);
  endtask
  task automatic rbyte(input logic [7:0] e);
    op(KIND_DOUT, 8'h00);
    ahb(1'b0, OFF_RDATA, 32'h0);
    check({24'h0, rd[7:0]}, {24'h0, e});
  endtask
  // reads one status bit, then clears the sticky refusal
  task automatic sbit(input int b, input logic e);
    ahb(1'b0, OFF_STAT, 32'h0);
    check({31'h0, rd[b]}, {31'h0, e});
    ahb(1'b1, OFF_STAT, 32'h4);
  endtask

  initial begin
    #3000000;
    error_cnt++;
    tally_and_finish;
  end

  initial begin
    repeat (12) @(posedge REF_CLK);
    ARST_N <= 1'b1;
    @(posedge REF_CLK);
    ahb(1'b0, OFF_CTRL, 32'h0);
    check(rd, {29'h0, CTRL_RST});
    ahb(1'b0, OFF_COL, 32'h0);
    check(rd, {18'h0, COL_RST});
    ahb(1'b1, OFF_CTRL, 32'h2);
    cmd(C_READ_ID);
    op(KIND_ADDR, 8'h00);
    for (int i = 0; i < 4; i++) op(KIND_DOUT, 8'h00);
    rbyte(8'h64);
    rbyte(8'h42);
    ahb(1'b0, OFF_ID, 32'h0);
    check(rd, 32'h00000159);
    cmd(C_READ_ID);
    op(KIND_ADDR, 8'h01);
    sbit(ST_REFUSED, 1'b1);
    cmd(C_PROG);
    adr5(8'h05, 8'h03);
    op(KIND_DIN, 8'hAA);
    op(KIND_DIN, 8'h55);
    cmd(C_PROG_CONF);
    sbit(ST_REFUSED, 1'b0);
    cmd(C_READ);
    adr5(8'h05, 8'h03);
    cmd(C_READ_CONF);
    rbyte(8'hAA);
    rbyte(8'h55);
    rbyte(8'h07);
    cmd(C_CACHE_NEXT);
    rbyte(8'h00);
    cmd(C_READ_ID);
    sbit(ST_REFUSED, 1'b1);
    cmd(C_CACHE_END);
    rbyte(8'h00);
    sbit(ST_CACHE, 1'b0);
    cmd(C_RD_COL);
    op(KIND_ADDR, 8'hC0);
    op(KIND_ADDR, 8'h21);
    sbit(ST_REFUSED, 1'b1);
    cmd(C_RESET);
    cmd(MP_RD);
    sbit(ST_REFUSED, 1'b1);
    cmd(C_PROG);
    adr5(8'h00, 8'h03);
    cmd(C_PROG_1ST);
    sbit(ST_MP_LOCK, 1'b1);
    cmd(C_READ_ID);
    sbit(ST_REFUSED, 1'b1);
    cmd(C_STATUS);
    rbyte(8'hC0);
    sbit(ST_REFUSED, 1'b0);
    cmd(C_RESET);
    ahb(1'b1, OFF_CTRL, 32'h6);
    cmd(C_READ_ID);
    op(KIND_ADDR, 8'h00);
    rbyte(MAKER_ID);
    tally_and_finish;
  end
endmodule

bind nand_host_ctrl nand_host_ctrl_properties i_nand_host_ctrl_properties (
  .REF_CLK(REF_CLK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR), .HWRITE(HWRITE),
  .HWDATA(HWDATA), .HTRANS(HTRANS), .HREADY(HREADY),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .NAND_PINS(NAND_PINS));
